// file: include/aab_pkg.sv
// Shared constants and types for the add, conjunction and bit-test datapath
package aab_pkg;

  // ----------------------------------------------------------------
  // Register map, byte addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_INSTR = 8'h04;
  localparam logic [7:0] OFS_IMM = 8'h08;
  localparam logic [7:0] OFS_ADDR = 8'h0C;
  localparam logic [7:0] OFS_MEMOP = 8'h10;
  localparam logic [7:0] OFS_FLAGS = 8'h14;
  localparam logic [7:0] OFS_RESULT = 8'h18;
  localparam logic [7:0] OFS_STATUS = 8'h1C;
  localparam logic [7:0] OFS_EADDR = 8'h20;
  localparam logic [7:0] OFS_RF_BASE = 8'h40;
  localparam logic [1:0] RF_SEL = 2'h1;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CTRL_GO_BIT = 8;
  localparam int CTRL_OP_HI = 2;
  localparam int CTRL_OP_LO = 0;
  localparam int INS_MODE_HI = 15;
  localparam int INS_MODE_LO = 14;
  localparam int INS_WB_BIT = 8;
  localparam int INS_SRC_HI = 7;
  localparam int INS_SRC_LO = 4;
  localparam int INS_DST_HI = 3;
  localparam int INS_DST_LO = 0;
  localparam int STAT_ILLEGAL_BIT = 3;
  localparam int RF_ENTRIES = 16;

  // ----------------------------------------------------------------
  // Encodings
  // ----------------------------------------------------------------
  localparam logic [1:0] MODE_IMM_IND = 2'h0;
  localparam logic [1:0] MODE_DIR_IDX = 2'h1;
  localparam logic [1:0] MODE_REG = 2'h2;
  localparam logic [3:0] FIELD_ZERO = 4'h0;
  localparam logic [31:0] MASK_BYTE = 32'h0000_00FF;
  localparam logic [31:0] MASK_WORD = 32'h0000_FFFF;
  localparam logic [31:0] MASK_LONG = 32'hFFFF_FFFF;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] RST_HALF = 16'h0000;
  localparam logic [31:0] RST_FULL = 32'h0000_0000;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [2:0] RST_OP = 3'h0;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    OP_PLAIN_SUM = 3'h0,
    OP_SUM_WITH_CARRY_IN = 3'h1,
    OP_LOGICAL_CONJUNCTION = 3'h2,
    OP_POSITION_TEST_IMM = 3'h3,
    OP_LONG_PLAIN_SUM = 3'h4,
    OP_POSITION_TEST_REG = 3'h5
  } aab_op_e;

  typedef enum logic [1:0] {
    W_BYTE = 2'h0,
    W_WORD = 2'h1,
    W_LONG = 2'h2
  } aab_width_e;

  typedef enum logic [2:0] {
    AM_REG = 3'h0,
    AM_IMM = 3'h1,
    AM_IND = 3'h2,
    AM_DIR = 3'h3,
    AM_IDX = 3'h4,
    AM_BAD = 3'h7
  } aab_amode_e;

  // Bit order matches the flags byte seen by software: C at bit 7
  typedef struct packed {
    logic c;
    logic z;
    logic s;
    logic pv;
    logic d;
    logic h;
    logic [1:0] rsvd;
  } aab_flags_s;

endpackage

// file: core/aab_flag_unit.sv
// Combinational arithmetic, conjunction and bit-test unit with flag logic
`timescale 1ns/1ns
module aab_flag_unit (
  input wire aab_pkg::aab_op_e op,
  input wire aab_pkg::aab_width_e width,
  input wire logic [31:0] dstOp,
  input wire logic [31:0] srcOp,
  input wire logic [3:0] bitNum,
  input wire aab_pkg::aab_flags_s flagsIn,
  output logic [31:0] result,
  output aab_pkg::aab_flags_s flagsOut
);

  // ----------------------------------------------------------------
  // Adders, one per width
  // ----------------------------------------------------------------
  wire carryIn = (op == aab_pkg::OP_SUM_WITH_CARRY_IN) & flagsIn.c;
  wire [8:0] sumB = {1'b0, dstOp[7:0]} + {1'b0, srcOp[7:0]} + {8'h00, carryIn};
  wire [16:0] sumW = {1'b0, dstOp[15:0]} + {1'b0, srcOp[15:0]} + {16'h0000, carryIn};
  wire [32:0] sumL = {1'b0, dstOp} + {1'b0, srcOp} + {32'h0000_0000, carryIn};
  wire [4:0] nibSum = {1'b0, dstOp[3:0]} + {1'b0, srcOp[3:0]} + {4'h0, carryIn};

  wire isByte = (width == aab_pkg::W_BYTE);
  wire isWord = (width == aab_pkg::W_WORD);
  wire [31:0] widthMask = isByte ? aab_pkg::MASK_BYTE :
                          isWord ? aab_pkg::MASK_WORD : aab_pkg::MASK_LONG;
  wire [31:0] sumRes = isByte ? {24'h00_0000, sumB[7:0]} :
                       isWord ? {16'h0000, sumW[15:0]} : sumL[31:0];
  wire sumCarry = isByte ? sumB[8] : isWord ? sumW[16] : sumL[32];
  wire [31:0] andRes = dstOp & srcOp & widthMask;

  // Sign bits picked at the operand width, except andMsb, which takes bit 15 for both word and long
  wire dstMsb = isByte ? dstOp[7] : isWord ? dstOp[15] : dstOp[31];
  wire srcMsb = isByte ? srcOp[7] : isWord ? srcOp[15] : srcOp[31];
  wire sumMsb = isByte ? sumRes[7] : isWord ? sumRes[15] : sumRes[31];
  wire andMsb = isByte ? andRes[7] : andRes[15];
  wire testedBit = dstOp[bitNum];

  // ----------------------------------------------------------------
  // Result and flags
  // ----------------------------------------------------------------
  always_comb begin
    result = dstOp;
    flagsOut = flagsIn;
    unique case (op)
      aab_pkg::OP_PLAIN_SUM,
      aab_pkg::OP_SUM_WITH_CARRY_IN,
      aab_pkg::OP_LONG_PLAIN_SUM: begin
        result = sumRes;
        flagsOut.c = sumCarry;
        flagsOut.z = (sumRes == 32'h0000_0000);
        flagsOut.s = sumMsb;
        flagsOut.pv = (dstMsb == srcMsb) && (sumMsb != dstMsb);
        if (isByte) begin
          flagsOut.d = 1'b0;
          flagsOut.h = nibSum[4];
        end
      end
      aab_pkg::OP_LOGICAL_CONJUNCTION: begin
        result = andRes;
        flagsOut.z = (andRes == 32'h0000_0000);
        flagsOut.s = andMsb;
        if (isByte) begin
          flagsOut.pv = ~^andRes[7:0];
        end
      end
      aab_pkg::OP_POSITION_TEST_IMM,
      aab_pkg::OP_POSITION_TEST_REG: begin
        flagsOut.z = ~testedBit;
      end
      default: begin
        result = dstOp;
      end
    endcase
  end

endmodule // aab_flag_unit

// file: core/aab_alu_core.sv
// AHB-Lite reachable add, conjunction and bit-test datapath with register file
`timescale 1ns/1ns
module aab_alu_core (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [15:0] regFile_r [0:aab_pkg::RF_ENTRIES-1];
  logic [15:0] instr_r;
  logic [31:0] imm_r;
  logic [15:0] addr_r;
  logic [31:0] memOp_r;
  aab_pkg::aab_flags_s flags_r;
  logic [31:0] result_r;
  logic [7:0] status_r;
  logic [15:0] effAddr_r;
  logic [2:0] lastOp_r;
  logic dpWrite_r;
  logic [7:0] dpAddr_r;
  logic [31:0] hrdata_r;
  logic hreadyout_r;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  // Zero wait state slave: every address phase is taken when hready is high
  wire addrPhase = hsel & htrans[1] & hready;
  wire rdTake = addrPhase & ~hwrite;
  wire [7:0] aOfs = haddr[7:0];
  wire wrCtrl = dpWrite_r & (dpAddr_r == aab_pkg::OFS_CTRL);
  wire wrInstr = dpWrite_r & (dpAddr_r == aab_pkg::OFS_INSTR);
  wire wrImm = dpWrite_r & (dpAddr_r == aab_pkg::OFS_IMM);
  wire wrAddr = dpWrite_r & (dpAddr_r == aab_pkg::OFS_ADDR);
  wire wrMemOp = dpWrite_r & (dpAddr_r == aab_pkg::OFS_MEMOP);
  wire wrFlags = dpWrite_r & (dpAddr_r == aab_pkg::OFS_FLAGS);
  wire rdInRf = (aOfs[7:6] == aab_pkg::RF_SEL) & (aOfs[1:0] == 2'h0);
  // Upper address bits are not decoded; the map repeats every 256 bytes
  wire [15:0] rfRdWord = regFile_r[aOfs[5:2]];

  // ----------------------------------------------------------------
  // Instruction decode
  // ----------------------------------------------------------------
  // Execution starts on the data phase of a CTRL write with the go bit set
  wire execGo = wrCtrl & hwdata[aab_pkg::CTRL_GO_BIT];
  wire [2:0] opCode = hwdata[aab_pkg::CTRL_OP_HI:aab_pkg::CTRL_OP_LO];
  aab_pkg::aab_op_e op;
  assign op = aab_pkg::aab_op_e'(opCode);
  wire opKnown = (opCode <= 3'h5);
  wire [1:0] mode = instr_r[aab_pkg::INS_MODE_HI:aab_pkg::INS_MODE_LO];
  wire wbSel = instr_r[aab_pkg::INS_WB_BIT];
  wire [3:0] srcField = instr_r[aab_pkg::INS_SRC_HI:aab_pkg::INS_SRC_LO];
  wire [3:0] dstField = instr_r[aab_pkg::INS_DST_HI:aab_pkg::INS_DST_LO];
  wire isTest = (op == aab_pkg::OP_POSITION_TEST_IMM) |
                (op == aab_pkg::OP_POSITION_TEST_REG);
  wire isRegTest = (op == aab_pkg::OP_POSITION_TEST_REG);
  wire isLong = (op == aab_pkg::OP_LONG_PLAIN_SUM);
  aab_pkg::aab_width_e width;
  assign width = isLong ? aab_pkg::W_LONG :
                 wbSel ? aab_pkg::W_WORD : aab_pkg::W_BYTE;

  // Bit tests address their destination; the others address their source
  wire [3:0] amField = isTest ? dstField : srcField;
  wire amZero = (amField == aab_pkg::FIELD_ZERO);
  aab_pkg::aab_amode_e amode;
  assign amode = (mode == aab_pkg::MODE_REG) ? aab_pkg::AM_REG :
                 (mode == aab_pkg::MODE_IMM_IND) ?
                   (amZero ? aab_pkg::AM_IMM : aab_pkg::AM_IND) :
                 (mode == aab_pkg::MODE_DIR_IDX) ?
                   (amZero ? aab_pkg::AM_DIR : aab_pkg::AM_IDX) :
                 aab_pkg::AM_BAD;

  // A register bit number needs a register destination; byte form only R0-R7
  wire regTestBad = isRegTest &
                    ((mode != aab_pkg::MODE_REG) | (~wbSel & srcField[3]));
  wire illegal = ~opKnown | (amode == aab_pkg::AM_BAD) |
                 (isTest & (amode == aab_pkg::AM_IMM)) | regTestBad;
  wire execOk = execGo & ~illegal;
  wire execWr = execOk & ~isTest;

  // ----------------------------------------------------------------
  // Operand fetch
  // ----------------------------------------------------------------
  // Byte register codes 0-7 are high halves, 8-15 low halves of R0-R7
  function automatic logic [31:0] readReg(input logic [3:0] num,
                                          input aab_pkg::aab_width_e wd);
    logic [15:0] entry;
    logic [31:0] val;
    entry = regFile_r[{1'b0, num[2:0]}];
    unique case (wd)
      aab_pkg::W_BYTE: val = {24'h00_0000, (num[3] ? entry[7:0] : entry[15:8])};
      aab_pkg::W_WORD: val = {16'h0000, regFile_r[num]};
      aab_pkg::W_LONG: val = {regFile_r[{num[3:1], 1'b0}], regFile_r[{num[3:1], 1'b1}]};
      default: val = 32'h0000_0000;
    endcase
    return val;
  endfunction

  wire [31:0] widthMask = (width == aab_pkg::W_BYTE) ? aab_pkg::MASK_BYTE :
                          (width == aab_pkg::W_WORD) ? aab_pkg::MASK_WORD :
                          aab_pkg::MASK_LONG;
  wire [31:0] memVal = memOp_r & widthMask;
  wire [31:0] immVal = imm_r & widthMask;
  wire [31:0] srcVal = (amode == aab_pkg::AM_REG) ? readReg(srcField, width) :
                       (amode == aab_pkg::AM_IMM) ? immVal : memVal;
  wire [31:0] dstVal = (isTest & (amode != aab_pkg::AM_REG)) ? memVal :
                       readReg(dstField, width);

  // Bit number: register form reads a word register, immediate form the field
  wire [15:0] bitSrcReg = regFile_r[srcField];
  wire [3:0] bitRaw = isRegTest ? bitSrcReg[3:0] : srcField;
  wire [3:0] bitNum = wbSel ? bitRaw : {1'b0, bitRaw[2:0]};

  // Effective address of a memory operand, reported to software
  wire [15:0] amBase = regFile_r[amField];
  wire [15:0] effAddr = (amode == aab_pkg::AM_IND) ? amBase :
                        (amode == aab_pkg::AM_DIR) ? addr_r :
                        (amode == aab_pkg::AM_IDX) ? 16'(addr_r + amBase) :
                        16'h0000;

  // ----------------------------------------------------------------
  // Execution unit
  // ----------------------------------------------------------------
  logic [31:0] aluRes;
  aab_pkg::aab_flags_s aluFlags;

  aab_flag_unit u_flag_unit (
    .op(op),
    .width(width),
    .dstOp(dstVal),
    .srcOp(srcVal),
    .bitNum(bitNum),
    .flagsIn(flags_r),
    .result(aluRes),
    .flagsOut(aluFlags)
  );

  // ----------------------------------------------------------------
  // Register file with write-back
  // ----------------------------------------------------------------
  for (genvar i = 0; i < aab_pkg::RF_ENTRIES; i++) begin : g_rf
    localparam logic [3:0] IDX = 4'(i);
    wire busHit = dpWrite_r & (dpAddr_r == 8'(aab_pkg::OFS_RF_BASE + {IDX, 2'b00}));
    wire longHit = (width == aab_pkg::W_LONG) & (dstField[3:1] == IDX[3:1]);
    wire wordHit = (width == aab_pkg::W_WORD) & (dstField == IDX);
    wire byteHit = (width == aab_pkg::W_BYTE) & ~IDX[3] & (dstField[2:0] == IDX[2:0]);
    wire hit = execWr & (longHit | wordHit | byteHit);
    // Byte results land only in their own half; the other half is kept
    wire hiLane = hit & (~byteHit | ~dstField[3]);
    wire loLane = hit & (~byteHit | dstField[3]);
    wire [15:0] wbVal = longHit ? (IDX[0] ? aluRes[15:0] : aluRes[31:16]) :
                        wordHit ? aluRes[15:0] : {aluRes[7:0], aluRes[7:0]};
    always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
        regFile_r[i] <= aab_pkg::RST_HALF;
      end else if (busHit) begin
        regFile_r[i] <= hwdata[15:0];
      end else begin
        if (hiLane) begin
          regFile_r[i][15:8] <= wbVal[15:8];
        end
        if (loLane) begin
          regFile_r[i][7:0] <= wbVal[7:0];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Software-written operand registers
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      instr_r <= aab_pkg::RST_HALF;
      imm_r <= aab_pkg::RST_FULL;
      addr_r <= aab_pkg::RST_HALF;
      memOp_r <= aab_pkg::RST_FULL;
    end else begin
      if (wrInstr) begin
        instr_r <= hwdata[15:0];
      end
      if (wrImm) begin
        imm_r <= hwdata;
      end
      if (wrAddr) begin
        addr_r <= hwdata[15:0];
      end
      if (wrMemOp) begin
        memOp_r <= hwdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // Flags, result and status
  // ----------------------------------------------------------------
  // A software write and an execution never share a cycle: both need a data phase
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      flags_r <= aab_pkg::RST_BYTE;
    end else if (wrFlags) begin
      flags_r <= {hwdata[7:2], 2'b00};
    end else if (execOk) begin
      flags_r <= aluFlags;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      result_r <= aab_pkg::RST_FULL;
      effAddr_r <= aab_pkg::RST_HALF;
      status_r <= aab_pkg::RST_BYTE;
      lastOp_r <= aab_pkg::RST_OP;
    end else if (execGo) begin
      lastOp_r <= opCode;
      status_r <= {4'h0, illegal, amode};
      if (!illegal) begin
        result_r <= aluRes;
        effAddr_r <= effAddr;
      end
    end
  end

  // ----------------------------------------------------------------
  // Bus slave
  // ----------------------------------------------------------------
  // Read data is fetched at the address phase so it stands for the data phase
  wire [31:0] rdMux = (aOfs == aab_pkg::OFS_CTRL) ? {29'h0000_0000, lastOp_r} :
                      (aOfs == aab_pkg::OFS_INSTR) ? {16'h0000, instr_r} :
                      (aOfs == aab_pkg::OFS_IMM) ? imm_r :
                      (aOfs == aab_pkg::OFS_ADDR) ? {16'h0000, addr_r} :
                      (aOfs == aab_pkg::OFS_MEMOP) ? memOp_r :
                      (aOfs == aab_pkg::OFS_FLAGS) ? {24'h00_0000, flags_r} :
                      (aOfs == aab_pkg::OFS_RESULT) ? result_r :
                      (aOfs == aab_pkg::OFS_STATUS) ? {24'h00_0000, status_r} :
                      (aOfs == aab_pkg::OFS_EADDR) ? {16'h0000, effAddr_r} :
                      rdInRf ? {16'h0000, rfRdWord} :
                      32'h0000_0000;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      dpWrite_r <= 1'b0;
      dpAddr_r <= aab_pkg::RST_BYTE;
    end else if (hready) begin
      dpWrite_r <= addrPhase & hwrite;
      dpAddr_r <= aOfs;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      hrdata_r <= aab_pkg::RST_FULL;
      hreadyout_r <= 1'b0;
    end else begin
      hreadyout_r <= 1'b1;
      if (rdTake) begin
        hrdata_r <= rdMux;
      end
    end
  end

  assign hrdata = hrdata_r;
  assign hreadyout = hreadyout_r;
  assign hresp = 1'b0;

  // Transfer size is not checked: only whole-word accesses are meaningful
  wire unusedSize = ^hsize;

endmodule // aab_alu_core

// file: sim/aab_alu_sva.sv
// Bus-side checker for the add, conjunction and bit-test datapath
`timescale 1ns/1ns
module aab_alu_sva (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata
);
  // ----------------------------------------------------------------
  // Shadow of the last transfer and the last go
  // ----------------------------------------------------------------
  logic take;
  logic sumOp;
  logic dpRd_r, dpWr_r, wb_r, goFw_r;
  logic [7:0] dpA_r;
  logic [2:0] op_r;
  assign take = hsel & htrans[1] & hready;
  assign sumOp = op_r < 3'h3;
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      {dpRd_r, dpWr_r, wb_r, goFw_r, dpA_r, op_r} <= '0;
    end else begin
      dpRd_r <= take & !hwrite;
      dpWr_r <= take & hwrite;
      dpA_r <= haddr[7:0];
      if (dpWr_r && dpA_r == aab_pkg::OFS_INSTR) begin
        wb_r <= hwdata[8];
      end
      if (dpWr_r && dpA_r == aab_pkg::OFS_CTRL && hwdata[8]) begin
        op_r <= hwdata[2:0];
        goFw_r <= 1'b1;
      end else if (dpWr_r && dpA_r == aab_pkg::OFS_FLAGS) begin
        goFw_r <= 1'b0;
      end
    end
  end
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  property p_okay; hresp == 1'b0; endproperty
  a_okay: assert property (p_okay) else $error("hresp not okay");
  property p_ready; $past(arst_n) |-> hreadyout; endproperty
  a_ready: assert property (p_ready) else $error("wait state inserted");
  // Read data must not drift between reads
  property p_hold; !(take && !hwrite) |=> $stable(hrdata); endproperty
  a_hold: assert property (p_hold) else $error("read data changed without a read");
  property p_flagPad;
    dpRd_r && dpA_r == aab_pkg::OFS_FLAGS |-> hrdata[1:0] == 2'b00 && hrdata[31:8] == 24'h0;
  endproperty
  a_flagPad: assert property (p_flagPad) else $error("flags unused bits set");
  property p_byteRes;
    dpRd_r && dpA_r == aab_pkg::OFS_RESULT && sumOp && !wb_r |-> hrdata[31:8] == 24'h0;
  endproperty
  a_byteRes: assert property (p_byteRes) else $error("byte result too wide");
  property p_wordRes;
    dpRd_r && dpA_r == aab_pkg::OFS_RESULT && sumOp && wb_r |-> hrdata[31:16] == 16'h0;
  endproperty
  a_wordRes: assert property (p_wordRes) else $error("word result too wide");
  property p_byteD;
    dpRd_r && dpA_r == aab_pkg::OFS_FLAGS && goFw_r && op_r < 3'h2 && !wb_r |-> !hrdata[3];
  endproperty
  a_byteD: assert property (p_byteD) else $error("byte sum left D set");
  property p_ctrlRb; dpRd_r && dpA_r == aab_pkg::OFS_CTRL |-> hrdata == {29'h0, op_r}; endproperty
  a_ctrlRb: assert property (p_ctrlRb) else $error("control readback wrong");
  property p_status;
    dpRd_r && dpA_r == aab_pkg::OFS_STATUS |->
      hrdata[31:4] == 28'h0 && (hrdata[2:0] <= 3'h4 || hrdata[2:0] == 3'h7);
  endproperty
  a_status: assert property (p_status) else $error("status mode code bad");
endmodule // aab_alu_sva

// file: sim/add_and_bittest_alu_tb.sv
// Self-checking bench for the add, conjunction and bit-test datapath
`timescale 1ns/1ns
module add_and_bittest_alu_tb;
  typedef struct packed {
    logic [15:0] ins;
    logic [2:0] op;
    logic [15:0] r2, r3;
    logic [31:0] imm;
    logic [7:0] fin;
    logic [31:0] eres;
    logic [7:0] efl;
  } aab_row_s;
  logic core_clk = 1'b0, arst_n = 1'b0, hsel = 1'b1, hwrite = 1'b0;
  logic [31:0] haddr = '0, hwdata = '0, hrdata, v;
  logic [1:0] htrans = 2'b00;
  logic [2:0] hsize = 3'b010;
  logic hready, hreadyout, hresp;
  int n_fail = 0, n_checks = 0;
  aab_row_s rows [0:10];
  logic [15:0] mIns [0:3] = '{16'h8132, 16'h0132, 16'h4102, 16'h4132};
  logic [31:0] mRes [0:3] = '{32'h0000_0011, 32'h0000_0101, 32'h0000_0101, 32'h0000_0101};
  logic [31:0] mEa [0:3] = '{32'h0000_0000, 32'h0000_0010, 32'h0000_0020, 32'h0000_0030};
  logic [31:0] mSt [0:3] = '{32'h0000_0000, 32'h0000_0002, 32'h0000_0003, 32'h0000_0004};
  assign hready = hreadyout;
  always #5 core_clk = ~core_clk;
  aab_alu_core uut (.core_clk(core_clk), .arst_n(arst_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata));
  // ----------------------------------------------------------------
  // Bus tasks
  // ----------------------------------------------------------------
  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic waitRdy;
    int k;
    k = 0;
    do begin
      @(posedge core_clk);
      k++;
    end while (hready !== 1'b1 && k < 50);
    if (hready !== 1'b1) begin
      n_fail++;
      $display("mismatch %0t bus hang", $time);
      finish_test();
    end
  endtask
  task automatic busWr(input logic [7:0] a, input logic [31:0] d);
    haddr <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= 1'b1;
    waitRdy();
    htrans <= 2'b00;
    hwdata <= d;
    waitRdy();
  endtask
  task automatic busRd(input logic [7:0] a, output logic [31:0] d);
    haddr <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= 1'b0;
    waitRdy();
    htrans <= 2'b00;
    waitRdy();
    d = hrdata;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rdChk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    busRd(a, d);
    chk(d, exp);
  endtask
  task automatic go(input logic [2:0] op);
    busWr(aab_pkg::OFS_CTRL, {23'h0, 1'b1, 5'h0, op});
  endtask
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    rows = '{
      '{16'h0002, 3'h0, 16'h7F00, 16'h0, 32'h1, 8'h88, 32'h80, 8'h34},
      '{16'h0002, 3'h1, 16'hFF00, 16'h0, 32'h0, 8'h80, 32'h0, 8'hC4},
      '{16'h0102, 3'h0, 16'h0344, 16'h0, 32'h11, 8'h0C, 32'h355, 8'h0C},
      '{16'h0102, 3'h1, 16'h7FFF, 16'h0, 32'h0, 8'h80, 32'h8000, 8'h30},
      '{16'h0002, 3'h4, 16'hFFFF, 16'hFFFF, 32'h1, 8'h0C, 32'h0, 8'hCC},
      '{16'h0002, 3'h2, 16'hC300, 16'h0, 32'h7B, 8'h9C, 32'h43, 8'h8C},
      '{16'h0102, 3'h2, 16'h8001, 16'h0, 32'hF000, 8'h10, 32'h8000, 8'h30},
      '{16'h8002, 3'h3, 16'hB200, 16'h0, 32'h0, 8'hA4, 32'hB2, 8'hE4},
      '{16'h81F2, 3'h3, 16'h8000, 16'h0, 32'h0, 8'h40, 32'h8000, 8'h00},
      '{16'h8132, 3'h5, 16'h0008, 16'h0013, 32'h0, 8'h40, 32'h8, 8'h00},
      '{16'h8032, 3'h5, 16'hEF00, 16'h000C, 32'h0, 8'h00, 32'hEF, 8'h40}};
    repeat (5) @(posedge core_clk);
    arst_n <= 1'b1;
    @(posedge core_clk);
    rdChk(aab_pkg::OFS_FLAGS, 32'h0);
    rdChk(aab_pkg::OFS_RESULT, 32'h0);
    rdChk(aab_pkg::OFS_STATUS, 32'h0);
    $display("reset values done");
    for (int i = 0; i < 11; i++) begin
      busWr(aab_pkg::OFS_FLAGS, {24'h0, rows[i].fin});
      busWr(8'h48, {16'h0, rows[i].r2});
      busWr(8'h4C, {16'h0, rows[i].r3});
      busWr(aab_pkg::OFS_IMM, rows[i].imm);
      busWr(aab_pkg::OFS_INSTR, {16'h0, rows[i].ins});
      go(rows[i].op);
      rdChk(aab_pkg::OFS_RESULT, rows[i].eres);
      rdChk(aab_pkg::OFS_FLAGS, {24'h0, rows[i].efl});
    end
    $display("operation table done");
    busWr(aab_pkg::OFS_MEMOP, 32'h0000_0100);
    busWr(aab_pkg::OFS_ADDR, 32'h0000_0020);
    busWr(8'h4C, 32'h0000_0010);
    for (int i = 0; i < 4; i++) begin
      busWr(8'h48, 32'h0000_0001);
      busWr(aab_pkg::OFS_INSTR, {16'h0, mIns[i]});
      go(3'h0);
      rdChk(aab_pkg::OFS_RESULT, mRes[i]);
      rdChk(aab_pkg::OFS_STATUS, mSt[i]);
      rdChk(aab_pkg::OFS_EADDR, mEa[i]);
    end
    rdChk(8'h4C, 32'h0000_0010);
    $display("addressing modes done");
    // Illegal mode must leave the last legal result alone
    busWr(aab_pkg::OFS_INSTR, 32'h0000_C132);
    go(3'h0);
    rdChk(aab_pkg::OFS_STATUS, 32'h0000_000F);
    rdChk(aab_pkg::OFS_RESULT, 32'h0000_0101);
    busWr(aab_pkg::OFS_INSTR, 32'h0000_8082);
    go(3'h5);
    busRd(aab_pkg::OFS_STATUS, v);
    chk(v & 32'h0000_0008, 32'h0000_0008);
    rdChk(aab_pkg::OFS_CTRL, 32'h0000_0005);
    busWr(8'h3C, 32'hFFFF_FFFF);
    rdChk(8'h3C, 32'h0);
    $display("illegal and unmapped done");
    arst_n <= 1'b0;
    repeat (3) @(posedge core_clk);
    arst_n <= 1'b1;
    @(posedge core_clk);
    rdChk(aab_pkg::OFS_FLAGS, 32'h0);
    rdChk(aab_pkg::OFS_CTRL, 32'h0);
    $display("second reset done");
    finish_test();
  end
endmodule // add_and_bittest_alu_tb

bind aab_alu_core aab_alu_sva chk (.core_clk(core_clk), .arst_n(arst_n), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
  .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata));
